// ---- core/asc_pkg.sv ----
// Package: constants for the asynchronous static memory controller
package asc_pkg;
   // Memory geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int WORDS = 131072;
   // Clock rate and period
   localparam int CLK_MHZ = 40;
   localparam int CLK_PS = 1000000 / CLK_MHZ;
   // Device timing figures in ns, slower grade so both grades are met
   localparam int ADDRESS_ACCESS_DELAY_NS = 15;
   localparam int DESELECT_POWERDOWN_DELAY_NS = 15;
   localparam int WRITE_RELEASE_FLOAT_DELAY_NS = 7;
   localparam int WRITE_DATA_LEAD_TIME_NS = 8;
   localparam int WRITE_PULSE_NS = 10;
   // Least times rounded up to whole cycles, at least one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction
   // Read wait: access delay plus one cycle to sample in
   localparam int READ_CYC = ns_to_cyc(ADDRESS_ACCESS_DELAY_NS) + 1;
   // Write strobe low time: pulse, and float delay plus data lead
   localparam int WR_A = ns_to_cyc(WRITE_PULSE_NS);
   localparam int WR_B = ns_to_cyc(WRITE_RELEASE_FLOAT_DELAY_NS + WRITE_DATA_LEAD_TIME_NS);
   localparam int WRITE_CYC = (WR_A > WR_B) ? WR_A : WR_B;
   localparam int PD_CYC = ns_to_cyc(DESELECT_POWERDOWN_DELAY_NS);
   localparam int CNT_W = 4;
   // Reset levels of the control pins (all inactive)
   localparam logic PIN_IDLE = 1'h1;
   typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WSET, ST_WR, ST_WEND} asc_state_t;
endpackage

// ---- core/asc_ctrl.sv ----
// Module: controller that drives an asynchronous 128K x 8 static memory
//
// Functional notes
// - A write happens while chip select and write strobe are both low.
// - A read happens with chip select and output drive low and write strobe high.
// - Write data is timed against whichever of chip select or write strobe rises first.
// - The controller must not drive data while the memory may still be driving it.
// - A strobe write with output drive low lasts at least float delay plus data lead.
// - For a select-started read the address is valid by chip select falling.
`timescale 1ns/1ps
module asc_ctrl
   import asc_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic REQ_VALID_I,
   input wire logic REQ_WRITE_I,
   input wire logic [asc_pkg::ADDR_W-1:0] REQ_ADDR_I,
   input wire logic [asc_pkg::DATA_W-1:0] REQ_WDATA_I,
   output logic REQ_READY_O,
   output logic RSP_VALID_O,
   output logic [asc_pkg::DATA_W-1:0] RSP_RDATA_O,
   output logic [asc_pkg::ADDR_W-1:0] WORD_SELECT_LINES_O,
   output logic CHIP_SELECT_N_O,
   output logic OUTPUT_DRIVE_N_O,
   output logic WRITE_STROBE_N_O,
   input wire logic [asc_pkg::DATA_W-1:0] DATA_PINS_I,
   output logic [asc_pkg::DATA_W-1:0] DATA_PINS_O,
   output logic DATA_PINS_OE_O
);
   import asc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Sequencer state and phase counter
   asc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;

   // Request latched at take, held on the pins for the whole access
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;

   // Read byte handed back to the requester
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   // Active-low memory controls and the data driver enable
   logic cs_n_reg, cs_n_next;
   logic oe_n_reg, oe_n_next;
   logic we_n_reg, we_n_next;
   logic doe_reg, doe_next;

   // Handshake flags toward the requester
   logic rdy_reg, rdy_next;
   logic rsp_reg, rsp_next;

   // Request accepted on this edge
   logic take_req;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Load value of a timed phase, cut to the counter width
   function automatic logic [CNT_W-1:0] cnt_load(input int cycles);
      return CNT_W'(cycles);
   endfunction

   // Last cycle of a timed phase
   function automatic logic cnt_last(input logic [CNT_W-1:0] count);
      return count == CNT_W'(1);
   endfunction

   // One cycle of a timed phase gone
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] count);
      return count - CNT_W'(1);
   endfunction

   // Only an idle, ready controller takes a request
   assign take_req = REQ_VALID_I && rdy_reg;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Sequencer for read and write cycles on the pins
   always_comb begin
      // Hold everything but the answer pulse unless a phase moves it
      state_next = state_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      cs_n_next = cs_n_reg;
      oe_n_next = oe_n_reg;
      we_n_next = we_n_reg;
      doe_next = doe_reg;
      rdy_next = rdy_reg;
      rsp_next = 1'h0; // Answer pulse lasts one cycle
      case (state_reg)
         ST_IDLE: begin
            // Bus quiet and ready while nothing is pending
            cs_n_next = PIN_IDLE; // Deselect for standby
            oe_n_next = PIN_IDLE;
            we_n_next = PIN_IDLE;
            doe_next = 1'h0;
            rdy_next = 1'h1;
            if (take_req) begin
               rdy_next = 1'h0;
               addr_next = REQ_ADDR_I; // Address on the same edge select falls for a read, a cycle before it for a write
               wdata_next = REQ_WDATA_I;
               if (REQ_WRITE_I) begin
                  // Address settles one cycle before the write starts
                  state_next = ST_WSET;
               end else begin
                  cs_n_next = 1'h0; // Read with strobe high
                  oe_n_next = 1'h0;
                  cnt_next = cnt_load(READ_CYC);
                  state_next = ST_RD;
               end
            end
         end
         ST_RD: begin
            // Wait the access delay then sample
            if (cnt_last(cnt_reg)) begin
               rdata_next = DATA_PINS_I;
               rsp_next = 1'h1;
               cs_n_next = 1'h1;
               oe_n_next = 1'h1;
               cnt_next = cnt_load(PD_CYC); // Standby settle time
               state_next = ST_WEND;
            end else begin
               cnt_next = cnt_step(cnt_reg);
            end
         end
         ST_WSET: begin
            // Output drive stays high so the memory never drives
            cs_n_next = 1'h0;
            we_n_next = 1'h0; // Write overlap starts
            doe_next = 1'h1;
            cnt_next = cnt_load(WRITE_CYC); // Long enough for float and lead
            state_next = ST_WR;
         end
         ST_WR: begin
            if (cnt_last(cnt_reg)) begin
               // Strobe rises first and ends the write
               we_n_next = 1'h1; // Data held past the ending edge
               cnt_next = cnt_load(PD_CYC);
               state_next = ST_WEND;
            end else begin
               cnt_next = cnt_step(cnt_reg);
            end
         end
         ST_WEND: begin
            // Release select and data one cycle after the strobe rose
            cs_n_next = 1'h1;
            doe_next = 1'h0;
            if (cnt_last(cnt_reg)) begin
               state_next = ST_IDLE;
               rdy_next = 1'h1;
            end else begin
               cnt_next = cnt_step(cnt_reg);
            end
         end
         default: begin
            // Unused code, back to a quiet bus
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Synchronous reset to idle, pins inactive
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         addr_reg <= '0;
         wdata_reg <= '0;
         rdata_reg <= '0;
         cs_n_reg <= PIN_IDLE;
         oe_n_reg <= PIN_IDLE;
         we_n_reg <= PIN_IDLE;
         doe_reg <= 1'h0;
         rdy_reg <= 1'h0; // Ready comes one cycle after release
         rsp_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         cs_n_reg <= cs_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         doe_reg <= doe_next;
         rdy_reg <= rdy_next;
         rsp_reg <= rsp_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Requester side, straight from flip-flops
   assign REQ_READY_O = rdy_reg;
   assign RSP_VALID_O = rsp_reg;
   assign RSP_RDATA_O = rdata_reg;

   // Memory address and controls, straight from flip-flops
   assign WORD_SELECT_LINES_O = addr_reg; // 17-bit word address
   assign CHIP_SELECT_N_O = cs_n_reg;
   assign OUTPUT_DRIVE_N_O = oe_n_reg;
   assign WRITE_STROBE_N_O = we_n_reg;

   // Write byte and its driver enable
   assign DATA_PINS_O = wdata_reg;
   assign DATA_PINS_OE_O = doe_reg;
endmodule

// ---- dv/asc_ctrl_asserts.sv ----
// Port assertions for the static memory controller
`timescale 1ns/1ps
module asc_ctrl_asserts
   import asc_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic REQ_VALID_I,
   input wire logic REQ_WRITE_I,
   input wire logic REQ_READY_O,
   input wire logic RSP_VALID_O,
   input wire logic [asc_pkg::ADDR_W-1:0] WORD_SELECT_LINES_O,
   input wire logic CHIP_SELECT_N_O,
   input wire logic OUTPUT_DRIVE_N_O,
   input wire logic WRITE_STROBE_N_O,
   input wire logic [asc_pkg::DATA_W-1:0] DATA_PINS_O,
   input wire logic DATA_PINS_OE_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   chk_no_clash: assert property (DATA_PINS_OE_O |-> OUTPUT_DRIVE_N_O)
      else $error("data driven while memory outputs enabled");
   chk_write_pins: assert property (!WRITE_STROBE_N_O |-> !CHIP_SELECT_N_O && DATA_PINS_OE_O)
      else $error("strobe low without select or data");
   chk_read_rsp: assert property ($fell(CHIP_SELECT_N_O) && WRITE_STROBE_N_O |-> ##2 RSP_VALID_O)
      else $error("read answer late");
   chk_take_read: assert property (REQ_VALID_I && REQ_READY_O && !REQ_WRITE_I |-> ##3 RSP_VALID_O)
      else $error("read answer not three cycles after take");
   chk_strobe_len: assert property ($fell(WRITE_STROBE_N_O) |=> $rose(WRITE_STROBE_N_O))
      else $error("strobe low time wrong");
   chk_data_hold: assert property ($rose(WRITE_STROBE_N_O) |-> !CHIP_SELECT_N_O && DATA_PINS_OE_O && $stable(DATA_PINS_O))
      else $error("write data not held at write end");
   chk_addr_steady: assert property (!CHIP_SELECT_N_O && !$past(CHIP_SELECT_N_O) |-> $stable(WORD_SELECT_LINES_O))
      else $error("address moved while selected");
   chk_idle_pins: assert property (REQ_READY_O |-> CHIP_SELECT_N_O && WRITE_STROBE_N_O && !DATA_PINS_OE_O)
      else $error("pins not idle while ready");
endmodule
bind asc_ctrl asc_ctrl_asserts chk (.*);

// ---- dv/asc_sram_model.sv ----
// Behavioural model of the 128K x 8 static memory
`timescale 1ns/1ps
module asc_sram_model
   import asc_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wdata_oe_i,
   output logic [DATA_W-1:0] dq_o
);
   logic [DATA_W-1:0] store [WORDS];
   logic [DATA_W-1:0] rd;
   logic drive;
   // Lookup settles after the access delay
   assign #(ADDRESS_ACCESS_DELAY_NS) rd = store[addr_i];
   // Drive only in a selected read; otherwise show the write byte if enabled, else the inverted lookup
   assign drive = !cs_n_i && !oe_n_i && we_n_i;
   assign dq_o = drive ? (wdata_oe_i ? 'x : rd) : (wdata_oe_i ? wdata_i : ~rd);
   // Store only while select and strobe overlap low
   always @* if (!cs_n_i && !we_n_i) store[addr_i] = dq_o;
endmodule

// ---- dv/testbench.sv ----
// Bench for the static memory controller
`timescale 1ns/1ps
module testbench;
   import asc_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, valid = 1'h0, wr = 1'h0;
   logic ready, rsp, cs_n, oe_n, we_n, doe;
   logic [ADDR_W-1:0] addr = '0, ma;
   logic [DATA_W-1:0] wdata = '0, rdata, dq, dout;
   int failures = 0, comparisons = 0, cycles = 0;
   asc_ctrl dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(wr),
      .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata), .REQ_READY_O(ready), .RSP_VALID_O(rsp),
      .RSP_RDATA_O(rdata), .WORD_SELECT_LINES_O(ma), .CHIP_SELECT_N_O(cs_n),
      .OUTPUT_DRIVE_N_O(oe_n), .WRITE_STROBE_N_O(we_n), .DATA_PINS_I(dq),
      .DATA_PINS_O(dout), .DATA_PINS_OE_O(doe));
   asc_sram_model mem (.addr_i(ma), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .wdata_i(dout), .wdata_oe_i(doe), .dq_o(dq));
   initial forever #12.5 clk = ~clk;
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One request held until taken; pins judged on the way, a read against d
   task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge clk);
      valid = 1'h1;
      wr = w;
      addr = a;
      wdata = d;
      @(posedge clk iff ready === 1'h1);
      @(negedge clk);
      valid = 1'h0;
      check(32'(ma), 32'(a));
      if (w) begin
         check(32'({cs_n, oe_n, we_n, doe}), 32'h0000000e);
         @(negedge clk);
         check(32'({cs_n, oe_n, we_n, doe}), 32'h00000005);
         check(32'(dout), 32'(d));
      end else begin
         check(32'({cs_n, oe_n, we_n, doe}), 32'h00000002);
         repeat (2) @(posedge clk);
         #1 check(32'(rsp), 32'h00000001);
         check(32'(rdata), 32'(d));
      end
   endtask
   // Idle pin levels after reset
   task automatic test_reset();
      @(negedge clk);
      check(32'({cs_n, oe_n, we_n, doe, ready}), 32'h0000001d);
      $display("test reset done");
   endtask
   // Writes then reads at the address ends and inside
   task automatic test_data();
      logic [ADDR_W-1:0] a [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
      foreach (a[i]) access(1'h1, a[i], a[i][7:0] ^ 8'h3c);
      foreach (a[i]) access(1'h0, a[i], a[i][7:0] ^ 8'h3c);
      $display("test data done");
   endtask
   // Request raised while busy is ignored
   task automatic test_refused();
      access(1'h1, 17'h00100, 8'h11);
      @(negedge clk);
      valid = 1'h1;
      wdata = 8'hee;
      @(negedge clk);
      valid = 1'h0;
      access(1'h0, 17'h00100, 8'h11);
      $display("test refused done");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      test_reset();
      test_data();
      test_refused();
      complete_run();
   end
endmodule
